// ==== rtl/sar_adc_control.sv ====
// APB-controlled sequencer for an 8-bit successive-approximation converter.
`timescale 1ns/1ps
// What this block does
// - One 8-bit successive-approximation converter fed from a multiplexer of two pins and three references.
// - Ratiometric: input at high reference gives FF, ground gives 00.
// - Input above high reference saturates to FF with no overflow flag.
// - Sample input once at conversion start, then trial D/A bits one by one.
// - Result monotonic in input voltage with every code reachable.
// - Each conversion takes 32 bus phase clock cycles, or 32 RC edges with RC selected, clock at least 1 MHz.
// - Input readings are taken in the quiet part of the driving clock.
// - Multiplexer routes one of two external pins at port bits 4 and 5.
// - Conversions repeat every 32 cycles, overwriting result, until control is rewritten.
// - Done flag clears on channel select, result read, or power off.
// - Three-bit channel: 0,1 pins; 4 high, 5 mid, 6 low reference.
// - Powered on with channel 0 or 1, that pin stops being digital.
module sar_adc_control (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_q,
	output logic             pready_q,
	output logic             pslverr_q,
	// Analog side.
	input  wire logic        rc_osc,
	input  wire logic        cmp_above,
	output logic       [7:0] dac_code_q,
	output logic       [2:0] mux_sel_q,
	output logic             sample_q,
	output logic             analog_on_q,
	output logic             rc_osc_en_q,
	output logic             pin4_digital_off_q,
	output logic             pin5_digital_off_q
);
	logic                             rc_s1_q, rc_s2_q, rc_s3_q, cmp_s1_q, cmp_s2_q;
	logic                             done_flag_q, rc_sel_q, power_q;
	logic [2:0]                       ch_q;
	logic [7:0]                       result_q;
	logic [4:0]                       step_q;
	logic [2:0]                       bit_q;
	logic [1:0]                       phase_q;
	sar_adc_pkg::conv_state_t         state_q;
	logic                             access, wr_ctrl, rd_result, restart, tick, trial;
	logic                             decide, done, map_hit;
	logic [7:0]                       ctrl_rd;

	// Pins from the analog side and the RC oscillator are asynchronous to pclk.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_s1_q  <= 1'b0;
			rc_s2_q  <= 1'b0;
			rc_s3_q  <= 1'b0;
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			rc_s1_q  <= rc_osc;
			rc_s2_q  <= rc_s1_q;
			rc_s3_q  <= rc_s2_q;
			cmp_s1_q <= cmp_above;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	assign map_hit   = paddr == sar_adc_pkg::CTRL_OFF || paddr == sar_adc_pkg::RESULT_OFF;
	assign access    = psel && penable && pready_q;
	assign wr_ctrl   = access && pwrite && paddr == sar_adc_pkg::CTRL_OFF;
	assign rd_result = access && !pwrite && paddr == sar_adc_pkg::RESULT_OFF;
	assign restart   = wr_ctrl;
	// Steps advance on every pclk, or on each synchronised RC rising edge.
	assign tick      = rc_sel_q ? (rc_s2_q && !rc_s3_q) : 1'b1;
	// The top bit goes on trial as sampling ends; later trials ride on the decide before them.
	assign trial     = tick && state_q == sar_adc_pkg::ST_SAMPLE
	                   && step_q == sar_adc_pkg::SAMPLE_LAST;
	assign decide    = tick && state_q == sar_adc_pkg::ST_BITS
	                   && phase_q == sar_adc_pkg::PHASE_DECIDE;
	assign done      = decide && bit_q == 3'h0;
	assign ctrl_rd   = {done_flag_q, rc_sel_q, power_q, 2'b00, ch_q};

	// One wait state per access; unmapped addresses answer with pslverr.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !map_hit;
			if (psel && penable && !pready_q && !pwrite) begin
				if (paddr == sar_adc_pkg::CTRL_OFF) begin
					prdata_q <= {24'h000000, ctrl_rd};
				end else if (paddr == sar_adc_pkg::RESULT_OFF) begin
					prdata_q <= {24'h000000, result_q};
				end else begin
					prdata_q <= 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{rc_sel_q, power_q} <= 2'b00;
			ch_q                <= sar_adc_pkg::CTRL_RESET[2:0];
		end else if (wr_ctrl) begin
			rc_sel_q <= pwdata[sar_adc_pkg::RC_SEL_BIT];
			power_q  <= pwdata[sar_adc_pkg::POWER_ON_BIT];
			ch_q     <= pwdata[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W];
		end
	end

	// The new result wins over a result-read clear in the same cycle; a control write in that cycle wins over the result.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag_q <= 1'b0;
			result_q    <= sar_adc_pkg::RESULT_RESET;
		end else if (done && !restart) begin
			done_flag_q <= 1'b1;
			result_q    <= {dac_code_q[7:1], cmp_s2_q};
		end else if (wr_ctrl || rd_result || !power_q) begin
			done_flag_q <= 1'b0;
		end
	end

	// Sampling window of eight steps, then three steps per bit. The decide step of one bit
	// puts the next bit on trial, so the comparator has two steps to pass its synchroniser.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sar_adc_pkg::ST_OFF;
			step_q  <= 5'h00;
			bit_q   <= sar_adc_pkg::BIT_MSB;
			phase_q <= 2'h0;
		end else if (restart || !power_q) begin
			state_q <= sar_adc_pkg::ST_OFF;
			step_q  <= 5'h00;
			bit_q   <= sar_adc_pkg::BIT_MSB;
			phase_q <= 2'h0;
		end else if (state_q == sar_adc_pkg::ST_OFF) begin
			state_q <= sar_adc_pkg::ST_SAMPLE;
		end else if (tick) begin
			step_q <= step_q + 5'h01;
			unique case (state_q)
				sar_adc_pkg::ST_SAMPLE: begin
					if (step_q == sar_adc_pkg::SAMPLE_LAST) begin
						state_q <= sar_adc_pkg::ST_BITS;
					end
				end
				sar_adc_pkg::ST_BITS: begin
					phase_q <= decide ? 2'h0 : phase_q + 2'h1;
					if (decide) begin
						bit_q <= bit_q - 3'h1;
					end
					if (done) begin
						state_q <= sar_adc_pkg::ST_SAMPLE;
					end
				end
				sar_adc_pkg::ST_OFF: begin
					state_q <= sar_adc_pkg::ST_SAMPLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mux_sel_q          <= 3'h0;
			sample_q           <= 1'b0;
			analog_on_q        <= 1'b0;
			rc_osc_en_q        <= 1'b0;
			pin4_digital_off_q <= 1'b0;
			pin5_digital_off_q <= 1'b0;
		end else begin
			mux_sel_q          <= ch_q;
			sample_q           <= power_q && state_q == sar_adc_pkg::ST_SAMPLE;
			analog_on_q        <= power_q;
			rc_osc_en_q        <= rc_sel_q;
			pin4_digital_off_q <= power_q && ch_q == sar_adc_pkg::CH_PIN4;
			pin5_digital_off_q <= power_q && ch_q == sar_adc_pkg::CH_PIN5;
		end
	end

	sar_code_reg u_code (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (state_q != sar_adc_pkg::ST_BITS),
		.trial   (trial),
		.decide  (decide),
		.bit_idx (bit_q),
		.keep    (cmp_s2_q),
		.code_q  (dac_code_q)
	);

	// Helper logic for the checks below.
	logic [4:0] gap_q;
	logic       gap_ok_q, all_hi_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q    <= 5'h00;
			gap_ok_q <= 1'b0;
			all_hi_q <= 1'b1;
		end else begin
			gap_q    <= (done || restart) ? 5'h00 : gap_q + 5'h01;
			gap_ok_q <= (done || gap_ok_q) && !restart && !rc_sel_q;
			if (state_q != sar_adc_pkg::ST_BITS) begin
				all_hi_q <= 1'b1;
			end else if (decide && !cmp_s2_q) begin
				all_hi_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_trial_set;
		trial ##1 dac_code_q[$past(bit_q)];
	endsequence

	chk_done_loads_result: assert property (
		done && !restart |=> done_flag_q && result_q[0] == $past(cmp_s2_q))
		else $error("result and flag not loaded together");
	chk_period_thirty_two: assert property (
		done && gap_ok_q && !rc_sel_q |-> gap_q == sar_adc_pkg::CONV_LAST)
		else $error("conversion period is not 32 cycles");
	chk_flag_off_clear: assert property (!power_q |=> !done_flag_q)
		else $error("done flag set while powered off");
	chk_flag_read_clear: assert property (rd_result && !done |=> !done_flag_q)
		else $error("result read did not clear flag");
	chk_pin_digital_off: assert property (
		power_q && ch_q == sar_adc_pkg::CH_PIN4 && !wr_ctrl |=> ##1 pin4_digital_off_q)
		else $error("pin 4 not released from digital use");
	chk_sample_before_bits: assert property (
		$rose(state_q == sar_adc_pkg::ST_BITS) |-> $past(sample_q)
		|| $past(state_q) == sar_adc_pkg::ST_SAMPLE) else $error("bits began without sample");
	chk_trial_sets_bit: assert property (trial |-> s_trial_set)
		else $error("trial bit not raised in D/A code");
	chk_decide_next_trial: assert property (
		decide && bit_q != 3'h0 && !restart |=> dac_code_q[$past(bit_q) - 3'h1])
		else $error("next bit not put on trial after decide");
	chk_saturate_full: assert property (
		done && all_hi_q && cmp_s2_q && !restart |=> result_q == sar_adc_pkg::CODE_FULL)
		else $error("input above reference did not give FF");
	chk_restart_on_write: assert property (
		wr_ctrl |=> state_q == sar_adc_pkg::ST_OFF
		##1 (!power_q || state_q == sar_adc_pkg::ST_SAMPLE))
		else $error("control write did not restart");
endmodule // sar_adc_control

// ==== rtl/sar_adc_pkg.sv ====
// Shared constants for the successive-approximation converter control.
package sar_adc_pkg;
	localparam logic [11:0] CTRL_OFF         = 12'h000;
	localparam logic [11:0] RESULT_OFF       = 12'h004;
	localparam int          DONE_BIT         = 7;
	localparam int          RC_SEL_BIT       = 6;
	localparam int          POWER_ON_BIT     = 5;
	localparam int          CH_LSB           = 0;
	localparam int          CH_W             = 3;
	localparam int          CODE_W           = 8;
	localparam logic [2:0]  CH_PIN4          = 3'h0;
	localparam logic [2:0]  CH_PIN5          = 3'h1;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic [7:0]  RESULT_RESET     = 8'h00;
	localparam logic [7:0]  CODE_FULL        = 8'hFF;
	localparam int          CONV_CYCLES      = 32;
	localparam int          SAMPLE_STEPS     = 8;
	localparam logic [4:0]  SAMPLE_LAST      = 5'(SAMPLE_STEPS - 1);
	localparam logic [4:0]  CONV_LAST        = 5'(CONV_CYCLES - 1);
	localparam logic [1:0]  PHASE_TRIAL      = 2'h0;
	localparam logic [1:0]  PHASE_DECIDE     = 2'h2;
	localparam logic [2:0]  BIT_MSB          = 3'h7;
	typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_BITS} conv_state_t;
endpackage

// ==== rtl/sar_code_reg.sv ====
// Successive-approximation code register that drives the D/A array.
`timescale 1ns/1ps
module sar_code_reg (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Step controls.
	input  wire logic       clear,
	input  wire logic       trial,
	input  wire logic       decide,
	input  wire logic [2:0] bit_idx,
	input  wire logic       keep,
	// Current trial code.
	output logic      [7:0] code_q
);
	for (genvar i = 0; i < 8; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				code_q[i] <= 1'b0;
			end else if (trial && bit_idx == 3'(i)) begin
				// The first trial is raised while the sequencer still reads as sampling.
				code_q[i] <= 1'b1;
			end else if (clear) begin
				code_q[i] <= 1'b0;
			end else if (decide && bit_idx == 3'(i)) begin
				// A bit whose trial stayed at or below the input is kept; otherwise it is cleared.
				code_q[i] <= keep;
			end else if (decide && {1'b0, bit_idx} == 4'(i + 1)) begin
				// The decide step also puts the next lower bit on trial.
				code_q[i] <= 1'b1;
			end
		end
	end
endmodule // sar_code_reg

// ==== verif/analog_side_model.sv ====
// Analog side model: input mux, sample hold, comparator and RC oscillator.
`timescale 1ns/1ps
module analog_side_model (
	// From the converter control.
	input  wire logic       pclk,
	input  wire logic [2:0] mux_sel_q,
	input  wire logic       sample_q,
	input  wire logic [7:0] dac_code_q,
	input  wire logic       rc_osc_en_q,
	// Pin levels; 255 stands for the high reference.
	input  wire logic [8:0] pin4_level,
	input  wire logic [8:0] pin5_level,
	// Comparator and oscillator.
	output logic            cmp_above,
	output logic            rc_osc
);
	logic [8:0] level;
	logic [8:0] held_q = 9'h000;
	always_comb begin
		case (mux_sel_q)
			3'h0: level = pin4_level;
			3'h1: level = pin5_level;
			3'h4: level = 9'h0FF;
			3'h5: level = 9'h080;
			3'h6: level = 9'h000;
			// Reserved inputs are given a moving level so nothing depends on them.
			default: level = {1'b0, ~dac_code_q};
		endcase
	end
	always @(posedge pclk) if (sample_q) held_q <= level;
	assign cmp_above = (held_q >= {1'b0, dac_code_q});
	initial rc_osc = 1'b0;
	// The oscillator only runs while enabled, as a powered-down RC would.
	always #333 rc_osc = (rc_osc_en_q === 1'b1) ? ~rc_osc : 1'b0;
endmodule // analog_side_model

// ==== verif/sar_adc_control_tb.sv ====
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module sar_adc_control_tb;
	logic        pclk, presetn, psel, penable, pwrite, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q, r;
	logic        pready_q, pslverr_q, rc_osc, cmp_above, sample_q, analog_on_q;
	logic        rc_osc_en_q, pin4_off, pin5_off;
	logic [7:0]  dac_code_q;
	logic [2:0]  mux_sel_q;
	int          bad_count, total_checks, n;
	time         t0;
	logic [2:0]  chans [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	logic [7:0]  exps  [5] = '{8'h5A, 8'hFF, 8'hFF, 8'h80, 8'h00};
	localparam logic [31:0] PON = 32'h1 << sar_adc_pkg::POWER_ON_BIT;
	localparam logic [31:0] RCS = 32'h1 << sar_adc_pkg::RC_SEL_BIT;
	localparam logic [31:0] DONE = 32'h1 << sar_adc_pkg::DONE_BIT;
	sar_adc_control i_sar_adc_control (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .rc_osc(rc_osc),
		.cmp_above(cmp_above), .dac_code_q(dac_code_q), .mux_sel_q(mux_sel_q),
		.sample_q(sample_q), .analog_on_q(analog_on_q), .rc_osc_en_q(rc_osc_en_q),
		.pin4_digital_off_q(pin4_off), .pin5_digital_off_q(pin5_off));
	analog_side_model i_analog_side_model (.pclk(pclk), .mux_sel_q(mux_sel_q),
		.sample_q(sample_q), .dac_code_q(dac_code_q), .rc_osc_en_q(rc_osc_en_q),
		.pin4_level(9'h05A), .pin5_level(9'h12C), .cmp_above(cmp_above), .rc_osc(rc_osc));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// Holds the request until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_q !== 1'b1);
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for the done flag, then checks the whole control word read with it.
	task automatic poll(input logic [31:0] ctrl);
		do apb(1'b0, sar_adc_pkg::CTRL_OFF, 32'h0); while (r[sar_adc_pkg::DONE_BIT] !== 1'b1);
		chk(r, ctrl | DONE);
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		bad_count++;
		end_of_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, sar_adc_pkg::CTRL_OFF, 32'h0);
		chk(r, 32'(sar_adc_pkg::CTRL_RESET));
		apb(1'b0, sar_adc_pkg::RESULT_OFF, 32'h0);
		chk(r, 32'(sar_adc_pkg::RESULT_RESET));
		apb(1'b0, 12'h008, 32'h0);
		chk({r[30:0], e}, 32'h1);
		$display("test reset and unmapped done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, sar_adc_pkg::CTRL_OFF, PON | 32'(chans[i]));
			repeat (3) @(posedge pclk);
			chk(32'({analog_on_q, mux_sel_q}), 32'({1'b1, chans[i]}));
			chk(32'({pin4_off, pin5_off}), 32'({chans[i] == 3'h0, chans[i] == 3'h1}));
			poll(PON | 32'(chans[i]));
			apb(1'b0, sar_adc_pkg::RESULT_OFF, 32'h0);
			chk(r, 32'(exps[i]));
			apb(1'b0, sar_adc_pkg::CTRL_OFF, 32'h0);
			chk(r, PON | 32'(chans[i]));
		end
		$display("test channels done");
		@(posedge sample_q);
		t0 = $time;
		@(posedge sample_q);
		chk(32'(($time - t0) / 5), sar_adc_pkg::CONV_CYCLES);
		poll(PON | 32'h6);
		apb(1'b1, sar_adc_pkg::CTRL_OFF, PON | 32'h6);
		apb(1'b0, sar_adc_pkg::CTRL_OFF, 32'h0);
		chk(r, PON | 32'h6);
		$display("test repeat and restart done");
		apb(1'b1, sar_adc_pkg::CTRL_OFF, 32'h0);
		apb(1'b0, sar_adc_pkg::CTRL_OFF, 32'h0);
		chk(r, 32'h0);
		chk(32'({analog_on_q, pin4_off, pin5_off}), 32'h0);
		apb(1'b1, sar_adc_pkg::CTRL_OFF, RCS | PON);
		repeat (3) @(posedge pclk);
		chk(32'(rc_osc_en_q), 32'h1);
		poll(RCS | PON);
		apb(1'b0, sar_adc_pkg::RESULT_OFF, 32'h0);
		chk(r, 32'h5A);
		apb(1'b1, sar_adc_pkg::CTRL_OFF, 32'h0);
		repeat (3) @(posedge pclk);
		chk(32'(rc_osc_en_q), 32'h0);
		$display("test rc clock done");
		end_of_test();
	end
endmodule // sar_adc_control_tb
